/* bench/tsa_master.sv */
// two-wire bus master model driving the port from the far side
// assumes a pull-up on sda, so a released line reads high
`default_nettype none
module tsa_master #(
  parameter int Q = 8
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // a quarter bit; must outlast the port's input filter delay
  task automatic tick;
    repeat (Q) @(negedge clk);
  endtask : tick
  task automatic start;
    sda = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask : start
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda_line;
    tick();
    scl = 1'b0;
    tick();
  endtask : bit_io
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : get
  task automatic stop;
    sda = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda = 1'b1;
    tick();
  endtask : stop
endmodule : tsa_master
`default_nettype wire

/* bench/tsa_port_bench.sv */
// self-checking bench for the two-wire register port
// assumes the master model tsa_master and the bound checker
`default_nettype none
module tsa_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADDR = {tsa_pkg::PART_CODE, 3'h5};
  logic clk = 1'b0, arst_n = 1'b0, var_sel = 1'b0, trig = 1'b0, done = 1'b0;
  logic scl, m_sda, sda_oe, cs, ca, po, im, sd, fo;
  logic a_hi = 1'b1, a_mid = 1'b0, a_lo = 1'b1;
  logic [9:0] acode = 10'h000;
  logic [9:0] tcode = 10'h155;
  logic [2:0] ch, fc;
  int err_count = 0, check_count = 0, aborts = 0, starts = 0, cyc = 0;
  wire sda_line = m_sda & ~sda_oe;
  always #50 clk = ~clk;
  tsa_master #(.Q(8)) i_bus (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(m_sda));
  tsa_port #(.CONV_PERIOD(50)) i_dut (.clk(clk), .arst_n(arst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .addr_select_hi_pin(a_hi),
    .addr_select_mid_pin(a_mid), .addr_select_lo_pin(a_lo), .single_input_variant(var_sel),
    .convert_trigger_pin(trig), .conv_done(done), .temp_code(tcode), .adc_code(acode),
    .conv_start(cs), .conv_abort(ca), .channel_sel(ch), .fault_count(fc),
    .overtemp_polarity(po), .interrupt_mode(im), .shutdown(sd), .filters_off(fo));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (ca === 1'b1) aborts++;
    if (cs === 1'b1) starts++;
    if (cyc == 80000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    logic a;
    i_bus.start();
    i_bus.put({ADDR, 1'b0}, a);
    chk("ack", 1, a);
    i_bus.put(p, a);
    if (n > 0) i_bus.put(d[15:8], a);
    if (n > 1) i_bus.put(d[7:0], a);
    i_bus.stop();
  endtask : wr
  // a read is a pointer-only write, then a fresh transfer in the other direction
  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] d);
    logic a;
    wr(p, 16'h0000, 0);
    i_bus.start();
    i_bus.put({ADDR, 1'b1}, a);
    i_bus.get(n == 1, d[15:8]);
    d[7:0] = 8'h00;
    if (n > 1) i_bus.get(1'b1, d[7:0]);
    i_bus.stop();
  endtask : rd
  task automatic wait_start(input string n);
    int k;
    k = 0;
    // starts are counted, since a restart can fall inside the closing stop
    while (starts == 0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(n, 1, k < 200);
  endtask : wait_start
  initial begin
    logic [15:0] v;
    logic a;
    int n;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    rd(8'h02, 2, v);
    chk("hyst", tsa_pkg::HYST_RESET, v);
    rd(8'h03, 2, v);
    chk("over", tsa_pkg::OVER_RESET, v);
    rd(8'h01, 1, v);
    chk("ctrl", {tsa_pkg::CTRL_RESET, 8'h00}, v);
    $display("test reset done");
    wr(8'h02, 16'h12ff, 2);
    wr(8'h03, 16'ha5ff, 1);
    rd(8'h02, 2, v);
    chk("hyst", 16'h1280, v);
    rd(8'h03, 2, v);
    chk("over", 16'ha500, v);
    $display("test limits done");
    for (int i = 0; i < 6; i++) begin
      v = {i[2:0], i[1:0], ~i[2:0], 8'h00};
      wr(8'h01, v, 1);
      chk("chan", (i < 5) ? i[2:0] : 3'h0, ch);
      chk("faults", (i[1:0] == 2'h0) ? 3'h1 : {i[1:0], 1'b0}, fc);
      chk("low", 3'(~i[2:0]), {po, im, sd});
      rd(8'h01, 1, v);
      chk("ctrl", {i[2:0], i[1:0], ~i[2:0], 8'h00}, v);
    end
    $display("test control done");
    wr(8'h05, 16'hff00, 1);
    chk("filt", 1, fo);
    rd(8'h05, 1, v);
    chk("ctrl2", 16'hc000, v);
    n = 0;
    repeat (200) @(negedge clk) n += int'(cs);
    chk("pinmode", 0, 16'(n));
    // finish the restart left by the last stop so that the pin edge is honoured
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    starts = 0;
    trig = 1'b1;
    wait_start("trig");
    trig = 1'b0;
    wr(8'h05, 16'h0000, 1);
    chk("filt", 0, fo);
    rd(8'h00, 2, v);
    chk("temp", {10'h155, 6'h00}, v);
    $display("test ctrl2 done");
    i_bus.start();
    i_bus.put({ADDR ^ 7'h01, 1'b0}, a);
    i_bus.stop();
    chk("nack", 0, a);
    var_sel = 1'b1;
    i_bus.start();
    i_bus.put({tsa_pkg::PART_CODE, 3'h0, 1'b0}, a);
    i_bus.stop();
    chk("ack0", 1, a);
    var_sel = 1'b0;
    {a_hi, a_mid, a_lo} = 3'h2;
    i_bus.start();
    i_bus.put({tsa_pkg::PART_CODE, 3'h2, 1'b0}, a);
    i_bus.stop();
    chk("ackpin", 1, a);
    {a_hi, a_mid, a_lo} = 3'h5;
    $display("test address done");
    wr(8'h01, 16'h2000, 1);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    starts = 0;
    wait_start("run");
    aborts = 0;
    starts = 0;
    rd(8'h02, 2, v);
    chk("abort", 1, aborts > 0);
    wait_start("restart");
    acode = 10'h2b5;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    rd(8'h04, 2, v);
    chk("result", {10'h2b5, 6'h00}, v);
    $display("test conversion done");
    report_and_stop();
  end
endmodule : tsa_port_bench
`default_nettype wire

/* bench/tsa_port_sva.sv */
// checker for the two-wire register port
// assumes it is bound to tsa_port and sees only its ports
`default_nettype none
module tsa_port_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [2:0] channel_sel,
  input wire logic [2:0] fault_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pull_only; sda_out == 1'b0; endproperty
  a_pull_only: assert property (p_pull_only) else $error("sda driven high");
  property p_ack_low; $rose(sda_oe) |-> !scl_in ##1 !scl_in; endproperty
  a_ack_low: assert property (p_ack_low) else $error("sda pulled with scl high");
  property p_release_low; $fell(sda_oe) |-> !$past(scl_in, 2); endproperty
  a_release_low: assert property (p_release_low) else $error("sda freed with scl high");
  property p_hold_high; $rose(scl_in) && sda_oe |=> sda_oe [*4]; endproperty
  a_hold_high: assert property (p_hold_high) else $error("sda moved in high phase");
  property p_conv_pulse; conv_start |=> !conv_start; endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");
  property p_abort_start; conv_abort |-> scl_in; endproperty
  a_abort_start: assert property (p_abort_start) else $error("abort away from start");
  property p_start_idle; conv_start |-> scl_in && !conv_abort; endproperty
  a_start_idle: assert property (p_start_idle) else $error("start during traffic");
  property p_fault_code; fault_count inside {3'h1, 3'h2, 3'h4, 3'h6}; endproperty
  a_fault_code: assert property (p_fault_code) else $error("bad fault count");
  property p_chan_range; channel_sel <= tsa_pkg::CH_MAX; endproperty
  a_chan_range: assert property (p_chan_range) else $error("bad channel");
endmodule : tsa_port_sva
bind tsa_port tsa_port_sva i_sva (.clk(clk), .arst_n(arst_n), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start), .conv_abort(conv_abort),
  .channel_sel(channel_sel), .fault_count(fault_count));
`default_nettype wire

/* rtl/tsa_pkg.sv */
// package for the temperature adc two-wire register port
// assumes a single 10 MHz clock domain and synchronous pin inputs
`default_nettype none
package tsa_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int CONV_PERIOD_US = 355;
  localparam int CONV_PERIOD_CYC = (CONV_PERIOD_US * (CLK_HZ / 1000000));
  localparam int ADDR_W = 7;
  localparam logic [3:0] PART_CODE = 4'h5; // arbitrary value
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CTRL = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_OVER = 3'h3;
  localparam logic [2:0] PTR_RESULT = 3'h4;
  localparam logic [2:0] PTR_CTRL2 = 3'h5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [15:0] HYST_RESET = 16'h4b00;
  localparam logic [15:0] OVER_RESET = 16'h5000;
  localparam logic [15:0] LIMIT_MASK = 16'hff80;
  localparam logic [15:0] RESULT_MASK = 16'hffc0;
  localparam logic [7:0] CTRL2_MASK = 8'hc0;
  localparam int CH_MSB = 7;
  localparam int CH_LSB = 5;
  localparam int FQ_MSB = 4;
  localparam int FQ_LSB = 3;
  localparam int POL_BIT = 2;
  localparam int MODE_BIT = 1;
  localparam int SHDN_BIT = 0;
  localparam int CMODE_BIT = 7;
  localparam int FILT_BIT = 6;
  localparam logic [2:0] CH_MAX = 3'h4;
  localparam int CODE_STEPS = 1024;
  typedef enum logic [2:0] {
    TSA_IDLE = 3'b000,
    TSA_ADDR = 3'b001,
    TSA_WACK = 3'b010,
    TSA_WRX = 3'b011,
    TSA_RTX = 3'b100,
    TSA_RACK = 3'b101,
    TSA_IGN = 3'b110
  } tsa_state_t;
endpackage : tsa_pkg
`default_nettype wire

/* rtl/tsa_port.sv */
// two-wire slave port and register set of a temperature sensing adc
// assumes scl/sda inputs synchronous to clk; sda is open drain via oe
`default_nettype none
module tsa_port #(
  parameter int CONV_PERIOD = tsa_pkg::CONV_PERIOD_CYC,
  parameter int FILT_LEN = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_hi_pin,
  input wire logic addr_select_mid_pin,
  input wire logic addr_select_lo_pin,
  input wire logic single_input_variant,
  input wire logic convert_trigger_pin,
  input wire logic conv_done,
  input wire logic [9:0] temp_code,
  input wire logic [9:0] adc_code,
  output logic conv_start,
  output logic conv_abort,
  output logic [2:0] channel_sel,
  output logic [2:0] fault_count,
  output logic overtemp_polarity,
  output logic interrupt_mode,
  output logic shutdown,
  output logic filters_off
);
  tsa_pkg::tsa_state_t state;
  logic [7:0] primary_control, secondary_control, pointer;
  logic [15:0] hysteresis_limit, overtemp_limit, temp_result, conversion_result;
  logic [2:0] scl_f, sda_f;
  logic scl_s, sda_s, scl_d, sda_d;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic byte_idx_hi, ptr_loaded, rd_lo;
  logic busy, converting, pend_restart;
  logic [31:0] period_cnt;
  logic trig_d;

  // glitch filter: a level must persist 3 samples unless disabled; FILT_LEN is not used
  function automatic logic filt(input logic [2:0] h, input logic cur, input logic off);
    if (off) return h[0];
    if (&h) return 1'b1;
    if (~|h) return 1'b0;
    return cur;
  endfunction : filt

  function automatic logic [15:0] reg_word(input logic [2:0] sel);
    unique case (sel)
      tsa_pkg::PTR_TEMP: reg_word = temp_result;
      tsa_pkg::PTR_CTRL: reg_word = {primary_control, 8'h00};
      tsa_pkg::PTR_HYST: reg_word = hysteresis_limit;
      tsa_pkg::PTR_OVER: reg_word = overtemp_limit;
      tsa_pkg::PTR_RESULT: reg_word = conversion_result;
      tsa_pkg::PTR_CTRL2: reg_word = {secondary_control, 8'h00};
      default: reg_word = 16'h0000;
    endcase
  endfunction : reg_word

  // word under the pointer, kept in a variable so that its bytes can be selected
  logic [15:0] rd_word;
  always_comb rd_word = reg_word(pointer[2:0]);

  wire logic [6:0] own_addr = single_input_variant ? {tsa_pkg::PART_CODE, 3'h0} :
    {tsa_pkg::PART_CODE, addr_select_hi_pin, addr_select_mid_pin, addr_select_lo_pin};
  wire logic start_c = scl_s && scl_d && sda_d && !sda_s;
  wire logic stop_c = scl_s && scl_d && !sda_d && sda_s;
  wire logic scl_rise = scl_s && !scl_d;
  wire logic scl_fall = !scl_s && scl_d;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_f <= 3'h7;
      sda_f <= 3'h7;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_f <= {scl_f[1:0], scl_in};
      sda_f <= {sda_f[1:0], sda_in};
      scl_s <= filt(scl_f, scl_s, filters_off);
      sda_s <= filt(sda_f, sda_s, filters_off);
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // byte engine; received data shifts in on scl rise, sent data shifts out on scl fall, sda changes only after scl fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= tsa_pkg::TSA_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      byte_idx_hi <= 1'b1;
      ptr_loaded <= 1'b0;
      rd_lo <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      primary_control <= tsa_pkg::CTRL_RESET;
      secondary_control <= tsa_pkg::CTRL2_RESET;
      hysteresis_limit <= tsa_pkg::HYST_RESET;
      overtemp_limit <= tsa_pkg::OVER_RESET;
    end else if (start_c) begin
      state <= tsa_pkg::TSA_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
      ptr_loaded <= 1'b0;
      byte_idx_hi <= 1'b1;
    end else if (stop_c) begin
      state <= tsa_pkg::TSA_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        tsa_pkg::TSA_IDLE, tsa_pkg::TSA_IGN: begin
          sda_oe <= 1'b0;
        end
        tsa_pkg::TSA_ADDR, tsa_pkg::TSA_WRX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (state == tsa_pkg::TSA_ADDR) begin
              if (shreg[7:1] == own_addr) begin
                sda_oe <= 1'b1;
                state <= tsa_pkg::TSA_WACK;
                rd_lo <= shreg[0];
              end else begin
                state <= tsa_pkg::TSA_IGN;
              end
            end else begin
              sda_oe <= 1'b1;
              state <= tsa_pkg::TSA_WACK;
              if (!ptr_loaded) begin
                pointer <= shreg;
                ptr_loaded <= 1'b1;
                byte_idx_hi <= 1'b1;
              end else begin
                byte_idx_hi <= 1'b0;
                unique case (pointer[2:0])
                  tsa_pkg::PTR_CTRL: primary_control <= shreg;
                  tsa_pkg::PTR_CTRL2: secondary_control <= shreg & tsa_pkg::CTRL2_MASK;
                  tsa_pkg::PTR_HYST: begin
                    if (byte_idx_hi) hysteresis_limit[15:8] <= shreg;
                    else hysteresis_limit[7:0] <= shreg & tsa_pkg::LIMIT_MASK[7:0];
                  end
                  tsa_pkg::PTR_OVER: begin
                    if (byte_idx_hi) overtemp_limit[15:8] <= shreg;
                    else overtemp_limit[7:0] <= shreg & tsa_pkg::LIMIT_MASK[7:0];
                  end
                  default: ;
                endcase
              end
            end
          end
        end
        tsa_pkg::TSA_WACK: begin
          // ack cycle ends on the ninth falling edge
          if (scl_fall) begin
            if (rd_lo && !ptr_loaded) begin
              // read transfer: first data bit goes out right away
              ptr_loaded <= 1'b1;
              shreg <= rd_word[15:8];
              byte_idx_hi <= 1'b0;
              sda_oe <= !rd_word[15];
              sda_out <= 1'b0;
              bitcnt <= 4'h0;
              state <= tsa_pkg::TSA_RTX;
            end else begin
              sda_oe <= 1'b0;
              state <= tsa_pkg::TSA_WRX;
            end
          end
        end
        tsa_pkg::TSA_RTX: begin
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              sda_oe <= 1'b0;
              state <= tsa_pkg::TSA_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= !shreg[6];
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        tsa_pkg::TSA_RACK: begin
          if (scl_rise) begin
            // a nack leaves the line to the master until stop
            rd_lo <= !sda_s;
          end else if (scl_fall) begin
            if (!rd_lo) begin
              state <= tsa_pkg::TSA_IGN;
            end else begin
              shreg <= byte_idx_hi ? rd_word[15:8] : rd_word[7:0];
              sda_oe <= byte_idx_hi ? !rd_word[15] : !rd_word[7];
              byte_idx_hi <= !byte_idx_hi;
              bitcnt <= 4'h0;
              rd_lo <= 1'b1;
              state <= tsa_pkg::TSA_RTX;
            end
          end
        end
        default: state <= tsa_pkg::TSA_IDLE;
      endcase
    end
  end

  // any addressed or unaddressed traffic counts as communication
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) busy <= 1'b0;
    else if (start_c) busy <= 1'b1;
    else if (stop_c) busy <= 1'b0;
  end

  // conversion scheduling; free-run period restarts after each start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_cnt <= 32'h0;
      converting <= 1'b0;
      pend_restart <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      trig_d <= convert_trigger_pin;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      // counted first so that the clear on a start below wins
      if (period_cnt < 32'(CONV_PERIOD - 1)) period_cnt <= period_cnt + 32'h1;
      if (converting && busy) begin
        converting <= 1'b0;
        conv_abort <= 1'b1;
        pend_restart <= 1'b1;
      end else if (converting && conv_done) begin
        converting <= 1'b0;
      end else if (!busy && !shutdown && !converting) begin
        if (pend_restart || (secondary_control[tsa_pkg::CMODE_BIT]
            ? (convert_trigger_pin && !trig_d)
            : (period_cnt >= 32'(CONV_PERIOD - 1)))) begin
          conv_start <= 1'b1;
          converting <= 1'b1;
          pend_restart <= 1'b0;
          period_cnt <= 32'h0;
        end
      end
    end
  end

  // results latched on completion; codes are straight binary steps of vref/1024
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_result <= 16'h0000;
      conversion_result <= 16'h0000;
    end else if (converting && conv_done && !busy) begin
      if (channel_sel == 3'h0) temp_result <= {temp_code, 6'h00};
      else conversion_result <= {adc_code, 6'h00} & tsa_pkg::RESULT_MASK;
    end
  end

  assign channel_sel = (primary_control[tsa_pkg::CH_MSB:tsa_pkg::CH_LSB] > tsa_pkg::CH_MAX)
    ? 3'h0 : primary_control[tsa_pkg::CH_MSB:tsa_pkg::CH_LSB];
  always_comb begin
    unique case (primary_control[tsa_pkg::FQ_MSB:tsa_pkg::FQ_LSB])
      2'b00: fault_count = 3'h1;
      2'b01: fault_count = 3'h2;
      2'b10: fault_count = 3'h4;
      2'b11: fault_count = 3'h6;
    endcase
  end
  assign overtemp_polarity = primary_control[tsa_pkg::POL_BIT];
  assign interrupt_mode = primary_control[tsa_pkg::MODE_BIT];
  assign shutdown = primary_control[tsa_pkg::SHDN_BIT];
  assign filters_off = secondary_control[tsa_pkg::FILT_BIT];
endmodule : tsa_port
`default_nettype wire
